// ### hdl/skew_clock_driver_control.sv
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module skew_clock_driver_control #(
   parameter int LOCK_EDGES = 4
) (
   input  wire logic        REF_CLK_IN,
   input  wire logic        RST_N_IN,
   input  wire logic [3:0]  AVS_ADDRESS_IN,
   input  wire logic        AVS_READ_IN,
   input  wire logic        AVS_WRITE_IN,
   input  wire logic [31:0] AVS_WRITEDATA_IN,
   input  wire logic [3:0]  AVS_BYTEENABLE_IN,
   output logic      [31:0] AVS_READDATA_OUT,
   output logic             AVS_WAITREQUEST_OUT,
   input  wire logic [1:0]  REFERENCE_0_IN,
   input  wire logic [1:0]  REFERENCE_1_IN,
   input  wire logic        LOOP_RETURN_IN,
   input  wire logic [1:0]  INPUT_STANDARD_SELECT_IN,
   input  wire logic [1:0]  OUTPUT_STANDARD_SELECT_IN,
   input  wire logic [29:0] BANK_FUNCTION_SELECT_IN,
   input  wire logic [5:0]  FEEDBACK_FUNCTION_SELECT_IN,
   input  wire logic [3:0]  FEEDBACK_DIVIDER_SELECT_IN,
   output logic      [9:0]  BANK_CLOCK_OUT,
   output logic      [9:0]  BANK_CLOCK_OE_OUT,
   output logic             FEEDBACK_CLOCK_OUT,
   output logic             FEEDBACK_CLOCK_N_OUT,
   output logic             FEEDBACK_CLOCK_OE_OUT,
   output logic             LOCK_OUT
);
   // Bus slave: one wait cycle, then the answer
   skew_drv_pkg::ctrl_s ctrl_q, ctrl_d;
   logic                ack_q, ack_d;
   logic [31:0]         rdata_q, rdata_d;
   logic                req;

   // Loop model
   logic                ref_q, ref_d;
   logic                ret_q, ret_d;
   logic [3:0]          phase_q, phase_d;
   logic [3:0]          ret_cnt_q, ret_cnt_d;
   logic [3:0]          streak_q, streak_d;
   logic                lock_q, lock_d;

   // Channels: banks 0..4, feedback 5
   logic [5:0]          raw_q, raw_d;
   logic [5:0]          lvl_q, lvl_d;
   logic [5:0]          run_q, run_d;
   logic [1:0]          div_q [6];
   logic [1:0]          div_d [6];
   logic [5:0]          val_q, val_d;
   logic [5:0]          oe_q, oe_d;

   logic                sel_ref;
   logic                ref_edge;
   logic                ret_edge;
   logic                pd_n;
   logic                rest;
   logic [3:0]          ratio;
   logic [3:0]          ret_now;
   typedef logic [1:0]  level_chk_t;
   level_chk_t          unused_chk;


   assign req                 = AVS_READ_IN | AVS_WRITE_IN;
   assign AVS_WAITREQUEST_OUT = req & ~ack_q;
   assign AVS_READDATA_OUT    = rdata_q;

   always_comb begin
      ctrl_d  = ctrl_q;
      ack_d   = req & ~ack_q;
      rdata_d = rdata_q;
      if (req && !ack_q && AVS_READ_IN) begin
         case (AVS_ADDRESS_IN)
            skew_drv_pkg::CTRL_OFS:   rdata_d = {21'h000000, ctrl_q};
            skew_drv_pkg::STATUS_OFS: rdata_d = {27'h0000000,
                  skew_drv_pkg::tl_level(OUTPUT_STANDARD_SELECT_IN),
                  skew_drv_pkg::tl_level(INPUT_STANDARD_SELECT_IN),
                  lock_q};
            skew_drv_pkg::CONFIG_OFS: rdata_d = {18'h00000, run_q, 4'h0, ratio};
            default:                  rdata_d = 32'h00000000;
         endcase
      end
      if (AVS_WRITE_IN && ack_q && AVS_ADDRESS_IN == skew_drv_pkg::CTRL_OFS) begin
         if (AVS_BYTEENABLE_IN[0]) begin
            ctrl_d[7:0] = AVS_WRITEDATA_IN[7:0];
         end
         if (AVS_BYTEENABLE_IN[1]) begin
            ctrl_d[10:8] = AVS_WRITEDATA_IN[10:8];
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         ctrl_q  <= skew_drv_pkg::CTRL_RESET;
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ctrl_q  <= ctrl_d;
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign unused_chk = 2'h0;

   // Reference front end and phase detector
   always_comb begin
      logic [1:0] pair;
      logic       r;
      r    = 1'b0;
      pair = ctrl_q.source_clock_choice ? REFERENCE_1_IN : REFERENCE_0_IN;
      if (skew_drv_pkg::tl_level(INPUT_STANDARD_SELECT_IN) == skew_drv_pkg::LVL_LOW) begin
         r = pair[1] & ~pair[0];
      end else begin
         r = pair[1];
      end
      pd_n    = ctrl_q.power_down_n;
      sel_ref = r & pd_n;
      ratio   = skew_drv_pkg::FB_RATIO[skew_drv_pkg::tl_index(FEEDBACK_DIVIDER_SELECT_IN)];
      rest    = ~ctrl_q.edge_polarity_select;
      ref_d   = sel_ref;
      ret_d   = LOOP_RETURN_IN & pd_n;
      // Both edges chosen by the same polarity bit
      ref_edge = ctrl_q.edge_polarity_select ? (sel_ref & ~ref_q) : (~sel_ref & ref_q);
      ret_edge = ctrl_q.edge_polarity_select ? (ret_d & ~ret_q) : (~ret_d & ret_q);
      ret_now  = (ret_edge && ret_cnt_q != 4'hF) ? ret_cnt_q + 4'h1 : ret_cnt_q;
      phase_d   = phase_q + (ctrl_q.vco_range_select ? skew_drv_pkg::STEP_HIGH
                                                      : skew_drv_pkg::STEP_LOW);
      ret_cnt_d = ret_now;
      streak_d  = streak_q;
      if (ref_edge) begin
         phase_d   = 4'h0;
         ret_cnt_d = 4'h0;
         if (ret_now == ratio) begin
            streak_d = (streak_q == 4'(LOCK_EDGES)) ? streak_q : streak_q + 4'h1;
         end else begin
            streak_d = 4'h0;
         end
      end
      if (ctrl_q.loop_bypass || !pd_n) begin
         streak_d = 4'h0;
      end
      if (!pd_n) begin
         phase_d   = phase_q;
         ret_cnt_d = ret_cnt_q;
      end
      lock_d = (streak_d == 4'(LOCK_EDGES));
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         ref_q     <= 1'b0;
         ret_q     <= 1'b0;
         phase_q   <= 4'h0;
         ret_cnt_q <= 4'h0;
         streak_q  <= 4'h0;
         lock_q    <= 1'b0;
      end else begin
         ref_q     <= ref_d;
         ret_q     <= ret_d;
         phase_q   <= phase_d;
         ret_cnt_q <= ret_cnt_d;
         streak_q  <= streak_d;
         lock_q    <= lock_d;
      end
   end

   // Output channels
   always_comb begin
      skew_drv_pkg::fn_s fn;
      logic [3:0]        sh;
      logic              src;
      logic              stop;
      sh   = 4'h0;
      src  = 1'b0;
      stop = 1'b0;
      for (int i = 0; i < skew_drv_pkg::CHANS; i++) begin
         if (i < skew_drv_pkg::BANKS) begin
            fn   = skew_drv_pkg::chan_fn(BANK_FUNCTION_SELECT_IN[6*i +: 6]);
            stop = ctrl_q.bank_stop_n[i];
         end else begin
            fn   = skew_drv_pkg::chan_fn(FEEDBACK_FUNCTION_SELECT_IN);
            stop = 1'b0;
         end
         // Positive skew lags the aligned phase
         sh        = phase_d - fn.skew;
         raw_d[i]  = (fn.mode == skew_drv_pkg::FN_INV) ? sh[3] : ~sh[3];
         div_d[i]  = (raw_d[i] & ~raw_q[i]) ? div_q[i] + 2'h1 : div_q[i];
         case (fn.mode)
            skew_drv_pkg::FN_DIV2: src = div_d[i][0];
            skew_drv_pkg::FN_DIV4: src = div_d[i][1];
            default:               src = raw_d[i];
         endcase
         if (ctrl_q.loop_bypass) begin
            src = sel_ref;
         end
         lvl_d[i] = src;
         run_d[i] = run_q[i];
         // Only switch where the output enters its rest level: no runt pulse
         if (src != lvl_q[i] && src == rest) begin
            run_d[i] = ~stop;
         end
         if (!pd_n) begin
            raw_d[i] = raw_q[i];
            div_d[i] = div_q[i];
            lvl_d[i] = lvl_q[i];
            run_d[i] = run_q[i];
         end
         if (!pd_n || !run_d[i]) begin
            oe_d[i]  = ctrl_q.stop_style_select;
            val_d[i] = ctrl_q.stop_style_select & rest;
         end else begin
            oe_d[i]  = 1'b1;
            val_d[i] = src;
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         raw_q <= 6'h00;
         lvl_q <= 6'h00;
         run_q <= 6'h3F;
         val_q <= 6'h00;
         oe_q  <= 6'h00;
         for (int i = 0; i < skew_drv_pkg::CHANS; i++) begin
            div_q[i] <= 2'h0;
         end
      end else begin
         raw_q <= raw_d;
         lvl_q <= lvl_d;
         run_q <= run_d;
         val_q <= val_d;
         oe_q  <= oe_d;
         for (int i = 0; i < skew_drv_pkg::CHANS; i++) begin
            div_q[i] <= div_d[i];
         end
      end
   end

   always_comb begin
      for (int b = 0; b < skew_drv_pkg::BANKS; b++) begin
         BANK_CLOCK_OUT[2*b +: 2]    = {2{val_q[b]}};
         BANK_CLOCK_OE_OUT[2*b +: 2] = {2{oe_q[b]}};
      end
   end

   assign FEEDBACK_CLOCK_OUT    = val_q[skew_drv_pkg::BANKS];
   // Complement rests opposite when gated, low when tri-stated
   assign FEEDBACK_CLOCK_N_OUT  = oe_q[skew_drv_pkg::BANKS]
                                  & ~val_q[skew_drv_pkg::BANKS];
   assign FEEDBACK_CLOCK_OE_OUT = oe_q[skew_drv_pkg::BANKS];
   assign LOCK_OUT              = lock_q;
endmodule : skew_clock_driver_control
`default_nettype wire

// ### include/skew_drv_pkg.sv
// Contract
// - Choice low uses pair 0, high pair 1
// - Stop input high stops bank synchronously
// - Stop style low tri-states, high gates
// - Gated rest level opposite to edge polarity
// - Align to chosen edge, polarity defaults high
// - Power-down freezes logic, outputs stopped by style
// - Feedback complement rests opposite the true side
// - Lock indicator high only while loop locked
// - Three-level pin picks reference input mode
// - Three-level pin picks output standard (here its level is only reported in the status register, outputs unchanged)
// - Three pins per channel pick 18 functions
// - Five banks of two plus feedback pair
// - Feedback divider ratios one to twelve
// - Banks can divide by two or four
// - Range pin picks oscillator rate
// - Open three-level pin reads as mid
// - Function codes map to skew, invert, divide
// - Divider codes map to fixed ratio table
// - Time unit is sixteenth of oscillator period
package skew_drv_pkg;
   localparam int          BANKS        = 5;
   localparam int          CHANS        = BANKS + 1;
   localparam logic [1:0]  TL_LOW       = 2'h0;
   localparam logic [1:0]  TL_HIGH      = 2'h3;
   localparam logic [3:0]  ZERO_IDX     = 4'h0;
   localparam logic [3:0]  LAST_IDX     = 4'h8;
   localparam logic [3:0]  STEP_LOW     = 4'h1;
   localparam logic [3:0]  STEP_HIGH    = 4'h2;
   localparam logic [3:0]  CTRL_OFS     = 4'h0;
   localparam logic [3:0]  STATUS_OFS   = 4'h4;
   localparam logic [3:0]  CONFIG_OFS   = 4'h8;
   localparam logic [10:0] CTRL_RESET   = 11'h006;
   localparam logic [3:0]  FB_RATIO [9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h1,
                                            4'h6, 4'h8, 4'hA, 4'hC};

   typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level_e;
   typedef enum logic [1:0] {FN_SKEW, FN_INV, FN_DIV2, FN_DIV4} fn_mode_e;

   typedef struct packed {
      fn_mode_e   mode;
      logic [3:0] skew;
   } fn_s;

   typedef struct packed {
      logic [4:0] bank_stop_n;
      logic       vco_range_select;
      logic       loop_bypass;
      logic       stop_style_select;
      logic       edge_polarity_select;
      logic       power_down_n;
      logic       source_clock_choice;
   } ctrl_s;

   function automatic level_e tl_level(input logic [1:0] pin);
      case (pin)
         TL_LOW:  return LVL_LOW;
         TL_HIGH: return LVL_HIGH;
         default: return LVL_MID;
      endcase
   endfunction : tl_level

   function automatic logic [3:0] tl_index(input logic [3:0] pins);
      return 4'(3 * int'(tl_level(pins[3:2])) + int'(tl_level(pins[1:0])));
   endfunction : tl_index

   function automatic fn_s chan_fn(input logic [5:0] sel);
      fn_s        r;
      logic [3:0] idx;
      idx    = tl_index(sel[3:0]);
      r.mode = FN_SKEW;
      r.skew = LAST_IDX - idx;
      if (tl_level(sel[5:4]) == LVL_HIGH) begin
         r.skew = ZERO_IDX - idx;
         if (idx == ZERO_IDX) begin
            r.mode = FN_INV;
         end else if (idx == LAST_IDX) begin
            r.mode = FN_DIV4;
         end
      end else if (idx == ZERO_IDX) begin
         r.mode = FN_DIV2;
      end
      return r;
   endfunction : chan_fn
endpackage : skew_drv_pkg

// ### dv/skew_drv_properties.sv
`timescale 1ns/1ps
`default_nettype none
module skew_drv_properties (
   input wire logic        REF_CLK_IN,
   input wire logic        RST_N_IN,
   input wire logic        AVS_READ_IN,
   input wire logic        AVS_WRITE_IN,
   input wire logic [31:0] AVS_READDATA_OUT,
   input wire logic        AVS_WAITREQUEST_OUT,
   input wire logic [9:0]  BANK_CLOCK_OUT,
   input wire logic [9:0]  BANK_CLOCK_OE_OUT,
   input wire logic        FEEDBACK_CLOCK_OUT,
   input wire logic        FEEDBACK_CLOCK_N_OUT,
   input wire logic        FEEDBACK_CLOCK_OE_OUT,
   input wire logic        LOCK_OUT
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   logic rd_wait_d;
   logic rd_wait_q;
   always_comb rd_wait_d = RST_N_IN && AVS_READ_IN && AVS_WAITREQUEST_OUT;
   always_ff @(posedge REF_CLK_IN) rd_wait_q <= rd_wait_d;

   chk_wait_once: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
      |=> !AVS_WAITREQUEST_OUT) else $error("wait longer than one cycle");
   chk_wait_first: assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT)
      else $error("no wait on first request cycle");
   chk_idle_free: assert property (!(AVS_READ_IN || AVS_WRITE_IN) |-> !AVS_WAITREQUEST_OUT)
      else $error("wait while idle");
   chk_rdata_hold: assert property ($changed(AVS_READDATA_OUT) |-> rd_wait_q)
      else $error("read data moved without a read");
   chk_pair_level: assert property ({BANK_CLOCK_OUT[8], BANK_CLOCK_OUT[6], BANK_CLOCK_OUT[4],
      BANK_CLOCK_OUT[2], BANK_CLOCK_OUT[0]} == {BANK_CLOCK_OUT[9], BANK_CLOCK_OUT[7],
      BANK_CLOCK_OUT[5], BANK_CLOCK_OUT[3], BANK_CLOCK_OUT[1]}) else $error("pair differs");
   chk_pair_enable: assert property (BANK_CLOCK_OE_OUT[0] == BANK_CLOCK_OE_OUT[1]
      && BANK_CLOCK_OE_OUT[8] == BANK_CLOCK_OE_OUT[9]) else $error("pair enable differs");
   chk_tri_zero: assert property ((BANK_CLOCK_OUT & ~BANK_CLOCK_OE_OUT) == 10'h000)
      else $error("released output not zero");
   chk_fb_opposite: assert property (FEEDBACK_CLOCK_OE_OUT |->
      FEEDBACK_CLOCK_N_OUT != FEEDBACK_CLOCK_OUT) else $error("feedback pair not opposite");
   chk_reset_quiet: assert property ($rose(RST_N_IN) |-> !LOCK_OUT
      && BANK_CLOCK_OE_OUT == 10'h000) else $error("outputs active out of reset");
   cover property (LOCK_OUT);
   cover property (BANK_CLOCK_OE_OUT[0] && BANK_CLOCK_OUT[0] && !FEEDBACK_CLOCK_OE_OUT);
   cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT);
endmodule : skew_drv_properties
bind skew_clock_driver_control skew_drv_properties skew_drv_properties_inst (
   .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .AVS_READ_IN(AVS_READ_IN),
   .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
   .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .BANK_CLOCK_OUT(BANK_CLOCK_OUT),
   .BANK_CLOCK_OE_OUT(BANK_CLOCK_OE_OUT), .FEEDBACK_CLOCK_OUT(FEEDBACK_CLOCK_OUT),
   .FEEDBACK_CLOCK_N_OUT(FEEDBACK_CLOCK_N_OUT),
   .FEEDBACK_CLOCK_OE_OUT(FEEDBACK_CLOCK_OE_OUT), .LOCK_OUT(LOCK_OUT));
`default_nettype wire

// ### dv/ref_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module ref_source_model #(
   parameter int HALF0 = 8,
   parameter int HALF1 = 16
) (
   input  wire logic       clk_in,
   input  wire logic       fb_in,
   output logic      [1:0] ref0_out,
   output logic      [1:0] ref1_out,
   output logic            ret_out
);
   int   c0 = 0;
   int   c1 = 0;
   logic t0 = 1'b0;
   logic t1 = 1'b0;
   always @(posedge clk_in) begin
      c0 = (c0 + 1) % HALF0;
      c1 = (c1 + 1) % HALF1;
      if (c0 == 0) t0 <= ~t0;
      if (c1 == 0) t1 <= ~t1;
      ret_out <= fb_in;
   end
   assign ref0_out = {t0, ~t0};
   assign ref1_out = {t1, ~t1};
endmodule : ref_source_model
`default_nettype wire

// ### dv/skew_clock_driver_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module skew_clock_driver_control_bench;
   logic        clk, rst_n, rd, wr, ret, fb_q, fb_n, fb_oe, lock, waitreq;
   logic [3:0]  addr, div_sel;
   logic [31:0] wdat, rdat, rdata;
   logic [1:0]  r0, r1, in_std, out_std;
   logic [29:0] bank_fn;
   logic [5:0]  fb_fn;
   logic [9:0]  bank_q, bank_oe;
   int          mismatches, tests_run, ctrl_m, n;
   int          ratio_q[$] = '{2, 3, 4, 5, 1, 6, 8, 10, 12};
   logic [1:0]  lv[3] = '{2'h0, 2'h1, 2'h3};

   skew_clock_driver_control #(.LOCK_EDGES(4)) skew_clock_driver_control_inst (
      .REF_CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'hF),
      .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .REFERENCE_0_IN(r0),
      .REFERENCE_1_IN(r1), .LOOP_RETURN_IN(ret), .INPUT_STANDARD_SELECT_IN(in_std),
      .OUTPUT_STANDARD_SELECT_IN(out_std), .BANK_FUNCTION_SELECT_IN(bank_fn),
      .FEEDBACK_FUNCTION_SELECT_IN(fb_fn), .FEEDBACK_DIVIDER_SELECT_IN(div_sel),
      .BANK_CLOCK_OUT(bank_q), .BANK_CLOCK_OE_OUT(bank_oe), .FEEDBACK_CLOCK_OUT(fb_q),
      .FEEDBACK_CLOCK_N_OUT(fb_n), .FEEDBACK_CLOCK_OE_OUT(fb_oe), .LOCK_OUT(lock));
   ref_source_model ref_source_model_inst (
      .clk_in(clk), .fb_in(fb_q), .ref0_out(r0), .ref1_out(r1), .ret_out(ret));

   function automatic int lvl(input logic [1:0] p);
      return (p == 2'h0) ? 0 : (p == 2'h3) ? 2 : 1;
   endfunction : lvl

   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdat <= d;
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      rdat = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : bus

   // Long settle covers a full output period before stop levels are sampled
   task automatic wctrl(input int v);
      ctrl_m = v & 'h7FF;
      bus(1'b1, 4'h0, 32'(v));
      repeat (40) @(posedge clk);
   endtask : wctrl

   task automatic wait_lock();
      for (int i = 0; i < 1000 && lock !== 1'b1; i++) @(posedge clk);
   endtask : wait_lock

   // Window of 128 cycles holds whole periods of 16, 32 and 64
   task automatic count_rises(input logic [5:0] f, output int cnt);
      logic prev;
      bank_fn[11:6] <= f;
      repeat (140) @(posedge clk);
      cnt = 0;
      prev = bank_q[2];
      for (int i = 0; i < 128; i++) begin
         @(posedge clk);
         cnt += (bank_q[2] === 1'b1 && prev === 1'b0) ? 1 : 0;
         prev = bank_q[2];
      end
   endtask : count_rises

   task automatic lag(input logic [5:0] f, output int d);
      logic prev;
      bank_fn[11:6] <= f;
      repeat (40) @(posedge clk);
      while (bank_q[0] !== 1'b0) @(posedge clk);
      while (bank_q[0] !== 1'b1) @(posedge clk);
      d = 0;
      prev = bank_q[2];
      while (d < 16) begin
         @(posedge clk);
         d++;
         if (bank_q[2] === 1'b1 && prev === 1'b0) break;
         prev = bank_q[2];
      end
   endtask : lag

   task automatic close_out();
      if (mismatches == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      close_out();
   end

   initial begin
      {rst_n, rd, wr, addr, wdat} = '0;
      in_std = 2'h0;
      out_std = 2'h3;
      bank_fn = {5{6'h0F}};
      fb_fn = 6'h0F;
      div_sel = 4'h5;
      void'($urandom(32'hD8A2F9F3));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, 4'h0, 32'h0);
      `CMP(rdat, 32'h006)
      bus(1'b0, 4'hC, 32'h0);
      `CMP(rdat, 32'h0)
      for (int i = 0; i < 4; i++) begin
         wctrl($urandom & 'h7FF);
         bus(1'b0, 4'h0, 32'h0);
         `CMP(rdat, 32'(ctrl_m))
      end
      for (int i = 0; i < 16; i++) begin
         in_std <= 2'(i >> 2);
         out_std <= 2'(i);
         repeat (3) @(posedge clk);
         bus(1'b0, 4'h4, 32'h0);
         `CMP(rdat[4:1], 4'(lvl(out_std) * 4 + lvl(in_std)))
      end
      for (int k = 0; k < 9; k++) begin
         div_sel <= {lv[k / 3], lv[k % 3]};
         repeat (3) @(posedge clk);
         bus(1'b0, 4'h8, 32'h0);
         `CMP(rdat[3:0], 4'(ratio_q[k]))
      end
      div_sel <= 4'h5;
      wctrl('h006);
      wait_lock();
      `CMP(lock, 1'b1)
      wctrl('h007);
      repeat (200) @(posedge clk);
      `CMP(lock, 1'b0)
      wctrl('h006);
      wait_lock();
      `CMP(lock, 1'b1)
      count_rises(6'h0F, n);
      `CMP(n, 8)
      count_rises(6'h00, n);
      `CMP(n, 4)
      count_rises(6'h3F, n);
      `CMP(n, 2)
      lag(6'h01, n);
      `CMP(n, 7)
      lag(6'h31, n);
      `CMP(n, 15)
      wctrl('h026);
      count_rises(6'h0F, n);
      `CMP(n, 16)
      wctrl('h016);
      `CMP(lock, 1'b0)
      wctrl('h04E);
      `CMP({bank_oe[3:0], bank_q[1:0]}, 6'h3C)
      wctrl('h04A);
      `CMP({bank_oe[3:0], bank_q[1:0]}, 6'h3F)
      wctrl('h046);
      `CMP(bank_oe[3:0], 4'hC)
      wctrl('h00C);
      `CMP({bank_oe, bank_q, fb_oe, fb_q, fb_n, lock}, {10'h3FF, 10'h000, 4'hA})
      wctrl('h004);
      `CMP({bank_oe, fb_oe}, 11'h000)
      close_out();
   end
endmodule : skew_clock_driver_control_bench
`default_nettype wire
